// ### rtl/can_xcvr_pkg.sv
package can_xcvr_pkg;
   // transceiver mode field encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_NORMAL = 2'h2;
   localparam logic [1:0] MODE_RXONLY = 2'h3;

   // register indices on the plain register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;

   // control register fields
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_WDOG_BIT = 2;
   // status register fields
   localparam int ST_WAKE_BIT = 0;
   localparam int ST_FAIL_BIT = 1;
   localparam int ST_ARMED_BIT = 2;
   localparam int ST_TXTO_BIT = 3;
   localparam int ST_MODE_LO = 4;
   localparam int ST_GATE_BIT = 6;

   // clock of the filter counters: 200 MHz
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PS_PER_NS = 1000;
   localparam int CNT_W = 24;

   // least time in ns -> whole cycles, rounded up, at least one
   function automatic int min_cycles(input int t_ns);
      int c;
      c = (t_ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // operating mode of the surrounding system chip
   typedef enum logic [2:0] {
      CHIP_NORMAL,
      CHIP_STOP,
      CHIP_SLEEP,
      CHIP_RESTART,
      CHIP_FAILSAFE
   } chip_mode_t;

   typedef enum logic [1:0] {
      WK_IDLE,
      WK_DOM1,
      WK_GAP,
      WK_DOM2
   } wake_state_t;

   // register port request bundle
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // all state of the transceiver control block
   typedef struct packed {
      logic [2:0] tx_sync;
      logic [2:0] bus_sync;
      logic tx_f;
      logic bus_f;
      logic [1:0] mode;
      logic wdog_bit;
      chip_mode_t chip_prev;
      logic armed;
      logic wake_hold;
      logic wake_flag;
      logic fail_flag;
      logic int_pend;
      logic txto;
      logic tx_gate;
      logic [CNT_W-1:0] en_cnt;
      logic [CNT_W-1:0] wk_cnt;
      logic [CNT_W-1:0] tx_cnt;
      logic [CNT_W-1:0] bus_cnt;
      wake_state_t wk;
      logic drv_en;
      logic drv_dom;
      logic hiz;
      logic rxd;
      logic int_n;
      logic restart;
      logic wdog_req;
      logic [DATA_W-1:0] rdata;
   } xcvr_state_t;
endpackage

// ### rtl/can_xcvr_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - after reset the transceiver is off: bus high impedance, nothing sent
// - in off mode bus wake activity is ignored and never reported
// - software picks the mode; normal only in chip normal or stop mode
// - normal mode drives the bus from transmit input, receive shows bus state
// - transmit low at end of enabling is ignored until transmit goes recessive
// - receive-only disables driver, keeps reception; only in chip normal or stop
// - wake capable allowed in stop, sleep, restart, normal; forced in fail-safe
// - wake needs two long dominant phases with a short recessive gap
// - on wake the receive output goes low until software changes the mode
// - after wake the mode field still reads wake capable, detection disarmed
// - leaving wake capable mode and returning rearms; flag clear not needed
// - chip entering stop, sleep or fail-safe rearms wake detection
// - wake in stop or normal: interrupt low, wake flag, receive low, no transition
// - wake in stop with watchdog-on-wake bit set requests watchdog enable
// - wake in sleep: request restart, receive low, record wake, no interrupt
// - long dominant transmit in normal mode: driver off, fail flag set
// - driver returns once transmit goes recessive; mode bits untouched
// - long dominant bus in any mode sets fail flag, mode untouched
module can_xcvr_ctrl #(
   parameter int T_EN_NS = 20000,
   parameter int WAKE_DOMINANT_FILTER_TIME_NS = 500,
   parameter int WAKE_RECESSIVE_GAP_TIME_NS = 1000000,
   parameter int T_TXTO_NS = 2000000,
   parameter int T_BUSTO_NS = 2000000
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic [can_xcvr_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [can_xcvr_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [can_xcvr_pkg::DATA_W-1:0] reg_rdata_out,
   input wire can_xcvr_pkg::chip_mode_t chip_mode_in,
   input wire logic can_tx_in,
   input wire logic bus_dominant_in,
   output logic drv_enable_out,
   output logic drv_dominant_out,
   output logic bus_hiz_out,
   output logic can_rx_out,
   output logic int_n_out,
   output logic restart_req_out,
   output logic wdog_enable_req_out
);
   // time figures turned into cycle counts
   localparam int EN_CYC = can_xcvr_pkg::min_cycles(T_EN_NS);
   localparam int WAKE1_CYC = can_xcvr_pkg::min_cycles(WAKE_DOMINANT_FILTER_TIME_NS);
   localparam int WAKE2_CYC = can_xcvr_pkg::min_cycles(WAKE_RECESSIVE_GAP_TIME_NS);
   localparam int TXTO_CYC = can_xcvr_pkg::min_cycles(T_TXTO_NS);
   localparam int BUSTO_CYC = can_xcvr_pkg::min_cycles(T_BUSTO_NS);
   localparam logic [can_xcvr_pkg::CNT_W-1:0] EN_C = can_xcvr_pkg::CNT_W'(EN_CYC);
   localparam logic [can_xcvr_pkg::CNT_W-1:0] WK1_C = can_xcvr_pkg::CNT_W'(WAKE1_CYC);
   localparam logic [can_xcvr_pkg::CNT_W-1:0] WK2_C = can_xcvr_pkg::CNT_W'(WAKE2_CYC);
   localparam logic [can_xcvr_pkg::CNT_W-1:0] TXTO_C = can_xcvr_pkg::CNT_W'(TXTO_CYC);
   localparam logic [can_xcvr_pkg::CNT_W-1:0] BUSTO_C = can_xcvr_pkg::CNT_W'(BUSTO_CYC);
   localparam logic [can_xcvr_pkg::CNT_W-1:0] CNT_ONE = 24'h000001;
   localparam logic [can_xcvr_pkg::CNT_W-1:0] CNT_MAX = 24'hFFFFFF;

   can_xcvr_pkg::xcvr_state_t st_q;
   can_xcvr_pkg::xcvr_state_t st_d;
   can_xcvr_pkg::reg_req_t req;
   logic [1:0] req_mode;
   logic mode_ok;
   logic wr_ctrl;
   logic wr_status;
   logic clr_wake;
   logic clr_fail;
   logic wake_det;
   logic rearm_chip;

   // saturating increment, shared by all four counters
   function automatic logic [can_xcvr_pkg::CNT_W-1:0] inc_sat(
      input logic [can_xcvr_pkg::CNT_W-1:0] c
   );
      return (c == CNT_MAX) ? c : c + CNT_ONE;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register port decode
   assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
   assign req_mode = req.wdata[can_xcvr_pkg::CTRL_MODE_LO +: 2];
   assign wr_ctrl = req.wr && (req.addr == can_xcvr_pkg::REG_CTRL);
   assign wr_status = req.wr && (req.addr == can_xcvr_pkg::REG_STATUS);
   // write one to clear the sticky flags
   assign clr_wake = wr_status && req.wdata[can_xcvr_pkg::ST_WAKE_BIT];
   assign clr_fail = wr_status && req.wdata[can_xcvr_pkg::ST_FAIL_BIT];

   // mode legality against chip mode; an illegal request leaves the mode alone
   always_comb begin
      case (req_mode)
         can_xcvr_pkg::MODE_OFF: mode_ok = 1'h1;
         can_xcvr_pkg::MODE_WAKE: mode_ok = (chip_mode_in != can_xcvr_pkg::CHIP_FAILSAFE);
         default: mode_ok = (chip_mode_in == can_xcvr_pkg::CHIP_NORMAL) ||
                            (chip_mode_in == can_xcvr_pkg::CHIP_STOP);
      endcase
   end

   // chip entering a low power or fail-safe mode rearms detection
   assign rearm_chip = (chip_mode_in != st_q.chip_prev) &&
                       ((chip_mode_in == can_xcvr_pkg::CHIP_STOP) ||
                        (chip_mode_in == can_xcvr_pkg::CHIP_SLEEP) ||
                        (chip_mode_in == can_xcvr_pkg::CHIP_FAILSAFE));

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_d = st_q;
      wake_det = 1'h0;
      // three flops per pin; a change counts once stages two and three agree
      st_d.tx_sync = {st_q.tx_sync[1:0], can_tx_in};
      st_d.bus_sync = {st_q.bus_sync[1:0], bus_dominant_in};
      if (st_q.tx_sync[1] == st_q.tx_sync[2]) begin
         st_d.tx_f = st_q.tx_sync[2];
      end
      if (st_q.bus_sync[1] == st_q.bus_sync[2]) begin
         st_d.bus_f = st_q.bus_sync[2];
      end
      st_d.chip_prev = chip_mode_in;

      // mode and configuration writes; any real change of mode drops the wake hold
      if (wr_ctrl) begin
         st_d.wdog_bit = req.wdata[can_xcvr_pkg::CTRL_WDOG_BIT];
         if (mode_ok && req_mode != st_q.mode) begin
            st_d.mode = req_mode;
            st_d.wake_hold = 1'h0;
            st_d.en_cnt = '0;
            st_d.tx_gate = 1'h0;
         end
      end
      if (chip_mode_in == can_xcvr_pkg::CHIP_FAILSAFE &&
          st_q.mode != can_xcvr_pkg::MODE_WAKE) begin
         st_d.mode = can_xcvr_pkg::MODE_WAKE;
         st_d.wake_hold = 1'h0;
      end
      // any mode other than wake capable leaves detection armed for the return
      if (st_d.mode != can_xcvr_pkg::MODE_WAKE || rearm_chip) begin
         st_d.armed = 1'h1;
      end

      // wake pattern filter: dominant > t1, recessive gap < t2, dominant > t1
      if (st_q.mode != can_xcvr_pkg::MODE_WAKE || !st_q.armed) begin
         st_d.wk = can_xcvr_pkg::WK_IDLE;
         st_d.wk_cnt = '0;
      end else begin
         st_d.wk_cnt = inc_sat(st_q.wk_cnt);
         case (st_q.wk)
            can_xcvr_pkg::WK_IDLE: begin
               st_d.wk_cnt = '0;
               if (st_q.bus_f) begin
                  st_d.wk = can_xcvr_pkg::WK_DOM1;
               end
            end
            can_xcvr_pkg::WK_DOM1: begin
               if (!st_q.bus_f) begin
                  st_d.wk_cnt = '0;
                  st_d.wk = (st_q.wk_cnt > WK1_C) ? can_xcvr_pkg::WK_GAP :
                            can_xcvr_pkg::WK_IDLE;
               end
            end
            can_xcvr_pkg::WK_GAP: begin
               if (st_q.bus_f) begin
                  st_d.wk_cnt = '0;
                  st_d.wk = can_xcvr_pkg::WK_DOM2;
               end else if (st_q.wk_cnt >= WK2_C) begin
                  st_d.wk = can_xcvr_pkg::WK_IDLE;
               end
            end
            can_xcvr_pkg::WK_DOM2: begin
               if (!st_q.bus_f) begin
                  st_d.wk = can_xcvr_pkg::WK_IDLE;
               end else if (st_q.wk_cnt > WK1_C) begin
                  wake_det = 1'h1;
                  st_d.wk = can_xcvr_pkg::WK_IDLE;
               end
            end
            default: st_d.wk = can_xcvr_pkg::WK_IDLE;
         endcase
      end

      // wake reaction depends on the chip mode; mode field stays wake capable
      st_d.restart = 1'h0;
      st_d.wdog_req = 1'h0;
      if (wake_det) begin
         st_d.armed = 1'h0;
         st_d.wake_hold = 1'h1;
         if (chip_mode_in == can_xcvr_pkg::CHIP_NORMAL ||
             chip_mode_in == can_xcvr_pkg::CHIP_STOP) begin
            st_d.int_pend = 1'h1;
         end else begin
            st_d.restart = 1'h1;
         end
         if (chip_mode_in == can_xcvr_pkg::CHIP_STOP && st_q.wdog_bit) begin
            st_d.wdog_req = 1'h1;
         end
      end

      // enabling time after entering normal; a low transmit level at the end waits
      // for recessive so a stuck-low controller cannot grab the bus
      if (st_q.mode == can_xcvr_pkg::MODE_NORMAL && !st_q.tx_gate) begin
         if (st_q.en_cnt < EN_C) begin
            st_d.en_cnt = inc_sat(st_q.en_cnt);
         end else if (st_q.tx_f) begin
            st_d.tx_gate = 1'h1;
         end
      end

      // transmit dominant time-out
      if (st_q.mode == can_xcvr_pkg::MODE_NORMAL && st_q.tx_gate && !st_q.tx_f) begin
         st_d.tx_cnt = inc_sat(st_q.tx_cnt);
         if (st_q.tx_cnt >= TXTO_C) begin
            st_d.txto = 1'h1;
         end
      end else begin
         st_d.tx_cnt = '0;
         st_d.txto = 1'h0;
      end

      // bus dominant clamp, watched in every mode
      st_d.bus_cnt = st_q.bus_f ? inc_sat(st_q.bus_cnt) : '0;

      // sticky flags: set wins over a clear in the same cycle
      if (clr_wake) begin
         st_d.wake_flag = 1'h0;
         st_d.int_pend = 1'h0;
      end
      if (clr_fail) begin
         st_d.fail_flag = 1'h0;
      end
      if (wake_det) begin
         st_d.wake_flag = 1'h1;
         if (st_d.restart == 1'h0) begin
            st_d.int_pend = 1'h1;
         end
      end
      if ((st_q.mode == can_xcvr_pkg::MODE_NORMAL && st_q.tx_gate && !st_q.tx_f &&
           st_q.tx_cnt >= TXTO_C) || st_q.bus_cnt >= BUSTO_C) begin
         st_d.fail_flag = 1'h1;
      end

      // pin outputs, registered from the current state
      st_d.drv_en = (st_q.mode == can_xcvr_pkg::MODE_NORMAL) && st_q.tx_gate &&
                    !st_q.txto;
      st_d.drv_dom = st_d.drv_en && !st_q.tx_f;
      st_d.hiz = (st_q.mode == can_xcvr_pkg::MODE_OFF);
      if (st_q.wake_hold) begin
         st_d.rxd = 1'h0;
      end else if (st_q.mode == can_xcvr_pkg::MODE_NORMAL ||
                   st_q.mode == can_xcvr_pkg::MODE_RXONLY) begin
         st_d.rxd = !st_q.bus_f;
      end else begin
         st_d.rxd = 1'h1;
      end
      st_d.int_n = !st_q.int_pend;

      // read data stand only in the cycle after the strobe
      st_d.rdata = '0;
      if (req.rd) begin
         if (req.addr == can_xcvr_pkg::REG_CTRL) begin
            st_d.rdata[can_xcvr_pkg::CTRL_MODE_LO +: 2] = st_q.mode;
            st_d.rdata[can_xcvr_pkg::CTRL_WDOG_BIT] = st_q.wdog_bit;
         end else if (req.addr == can_xcvr_pkg::REG_STATUS) begin
            st_d.rdata[can_xcvr_pkg::ST_WAKE_BIT] = st_q.wake_flag;
            st_d.rdata[can_xcvr_pkg::ST_FAIL_BIT] = st_q.fail_flag;
            st_d.rdata[can_xcvr_pkg::ST_ARMED_BIT] = st_q.armed;
            st_d.rdata[can_xcvr_pkg::ST_TXTO_BIT] = st_q.txto;
            st_d.rdata[can_xcvr_pkg::ST_MODE_LO +: 2] = st_q.mode;
            st_d.rdata[can_xcvr_pkg::ST_GATE_BIT] = st_q.tx_gate;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset lands in off mode with idle pin levels
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         st_q <= '0;
         st_q.tx_sync <= 3'h7;
         st_q.tx_f <= 1'h1;
         st_q.armed <= 1'h1;
         st_q.hiz <= 1'h1;
         st_q.rxd <= 1'h1;
         st_q.int_n <= 1'h1;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata_out = st_q.rdata;
   assign drv_enable_out = st_q.drv_en;
   assign drv_dominant_out = st_q.drv_dom;
   assign bus_hiz_out = st_q.hiz;
   assign can_rx_out = st_q.rxd;
   assign int_n_out = st_q.int_n;
   assign restart_req_out = st_q.restart;
   assign wdog_enable_req_out = st_q.wdog_req;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_tx_stuck;
      st_q.mode == can_xcvr_pkg::MODE_NORMAL && st_q.tx_gate && !st_q.tx_f &&
         st_q.tx_cnt >= TXTO_C;
   endsequence
   sequence s_tx_release;
      st_q.txto ##1 st_q.tx_f;
   endsequence

   a_reset_off_mode: assert property (@(posedge clk_sys_in)
      srst_in |=> st_q.mode == can_xcvr_pkg::MODE_OFF && bus_hiz_out && !drv_enable_out)
      else $error("reset did not land in off mode");
   a_off_no_wake: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      st_q.mode != can_xcvr_pkg::MODE_WAKE |-> !wake_det)
      else $error("wake reported outside wake capable mode");
   a_illegal_normal: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      wr_ctrl && req_mode == can_xcvr_pkg::MODE_NORMAL &&
      chip_mode_in == can_xcvr_pkg::CHIP_SLEEP |=> st_q.mode != can_xcvr_pkg::MODE_NORMAL)
      else $error("normal mode accepted in sleep");
   a_drive_follows_tx: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      drv_dominant_out |-> drv_enable_out && $past(!st_q.tx_f) &&
      $past(st_q.mode) == can_xcvr_pkg::MODE_NORMAL)
      else $error("dominant driven without cause");
   a_gate_needs_high: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      $rose(st_q.tx_gate) |-> $past(st_q.tx_f) && $past(st_q.en_cnt) >= EN_C)
      else $error("transmit opened early or while low");
   a_failsafe_wake: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      chip_mode_in == can_xcvr_pkg::CHIP_FAILSAFE |=> st_q.mode == can_xcvr_pkg::MODE_WAKE)
      else $error("fail-safe did not force wake capable mode");
   a_wake_rx_low: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      wake_det |=> st_q.wake_hold && st_q.mode == can_xcvr_pkg::MODE_WAKE && !st_q.armed
      ##1 !can_rx_out)
      else $error("wake did not pull receive low");
   a_chip_rearm: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      rearm_chip |=> st_q.armed)
      else $error("chip mode entry did not rearm");
   a_stop_wake_int: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      wake_det && chip_mode_in == can_xcvr_pkg::CHIP_STOP |=> ##1 !int_n_out && !restart_req_out)
      else $error("stop wake missed interrupt");
   a_sleep_wake: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      wake_det && chip_mode_in == can_xcvr_pkg::CHIP_SLEEP |=> restart_req_out && st_q.wake_flag
      && !st_q.int_pend)
      else $error("sleep wake handled wrongly");
   a_tx_timeout: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      s_tx_stuck |=> st_q.txto && st_q.fail_flag ##1 !drv_enable_out)
      else $error("transmit time-out did not cut the driver");
   a_tx_recover: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      s_tx_release |=> !st_q.txto && $stable(st_q.mode))
      else $error("driver not released after time-out");
   a_bus_clamp: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      st_q.bus_cnt >= BUSTO_C && !wr_ctrl |=> st_q.fail_flag && $stable(st_q.mode))
      else $error("bus clamp not flagged");
   a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (srst_in)
      st_q.fail_flag && !clr_fail |=> st_q.fail_flag)
      else $error("fail flag dropped without clear");
endmodule

// ### tb/can_ctrl_model.sv
`timescale 1ns/1ps
// protocol controller stand-in: drives the low-active transmit pin
module can_ctrl_model (
   input wire logic clk_sys_in,
   input wire logic dom_req_in,
   output logic can_tx_out
);
   // recessive at time zero so the pin is never unknown
   initial can_tx_out = 1'b1;
   // the bench keeps the request low until enabling ends, except where it means not to
   always @(posedge clk_sys_in) begin
      can_tx_out <= ~dom_req_in;
   end
endmodule

// ### tb/can_transceiver_mode_wake_ctrl_bench.sv
`timescale 1ns/1ps
module can_transceiver_mode_wake_ctrl_bench;
   logic clk_sys_in, srst_in, wr, rd, dom_req, can_tx, bus_dom;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, st;
   can_xcvr_pkg::chip_mode_t chip;
   logic drv_en, drv_dom, hiz, rx, int_n, rst_req, wdog_req, rst_seen, wdog_seen;
   int miscompares, n_compared, cycles;
   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   // short counts: enable 20, wake filter 10, gap 100, tx 40, bus 60 cycles
   can_xcvr_ctrl #(.T_EN_NS(100), .WAKE_DOMINANT_FILTER_TIME_NS(50), .WAKE_RECESSIVE_GAP_TIME_NS(500), .T_TXTO_NS(200),
      .T_BUSTO_NS(300)) can_xcvr_ctrl_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .chip_mode_in(chip), .can_tx_in(can_tx),
      .bus_dominant_in(bus_dom), .drv_enable_out(drv_en), .drv_dominant_out(drv_dom),
      .bus_hiz_out(hiz), .can_rx_out(rx), .int_n_out(int_n), .restart_req_out(rst_req),
      .wdog_enable_req_out(wdog_req));
   can_ctrl_model can_ctrl_model_inst (.clk_sys_in(clk_sys_in), .dom_req_in(dom_req),
      .can_tx_out(can_tx));
   // one-cycle request pulses are caught here so no scenario can miss them
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (rst_req === 1'b1) rst_seen <= 1'b1;
      if (wdog_req === 1'b1) wdog_seen <= 1'b1;
      if (cycles == 5000) begin
         miscompares++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] mask);
      @(posedge clk_sys_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 st = rdata & mask;
   endtask
   // two 20-cycle dominant phases around a 30-cycle recessive gap
   task automatic wup();
      bus_dom <= 1'b1;
      tick(20);
      bus_dom <= 1'b0;
      tick(30);
      bus_dom <= 1'b1;
      tick(20);
      bus_dom <= 1'b0;
      tick(10);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_off();
      chk({3'h0, hiz, drv_en, drv_dom, rx, int_n}, 8'h13);
      rd_reg(can_xcvr_pkg::REG_CTRL, 8'h07);
      chk(st, 8'h00);
      wup();
      chk({7'h0, rx}, 8'h01);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h04);
   endtask
   // refused writes must leave the mode as it was
   task automatic t_modes();
      chip <= can_xcvr_pkg::CHIP_SLEEP;
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h02);
      rd_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      chk(st, 8'h00);
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      rd_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      chk(st, 8'h00);
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h01);
      rd_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      chk(st, 8'h01);
      chip <= can_xcvr_pkg::CHIP_STOP;
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      rd_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      chk(st, 8'h03);
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h00);
      chip <= can_xcvr_pkg::CHIP_FAILSAFE;
      tick(3);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h30);
      chk(st, 8'h10);
      chip <= can_xcvr_pkg::CHIP_RESTART;
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h02);
      rd_reg(can_xcvr_pkg::REG_CTRL, 8'h03);
      chk(st, 8'h01);
      chip <= can_xcvr_pkg::CHIP_NORMAL;
   endtask
   // transmit held low across the enabling time on purpose
   task automatic t_normal();
      dom_req <= 1'b1;
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h02);
      tick(25);
      chk({6'h0, drv_en, drv_dom}, 8'h00);
      dom_req <= 1'b0;
      tick(8);
      chk({6'h0, drv_en, drv_dom}, 8'h02);
      dom_req <= 1'b1;
      tick(8);
      chk({6'h0, drv_en, drv_dom}, 8'h03);
      dom_req <= 1'b0;
      bus_dom <= 1'b1;
      tick(8);
      chk({7'h0, rx}, 8'h00);
      bus_dom <= 1'b0;
      tick(8);
      chk({7'h0, rx}, 8'h01);
   endtask
   task automatic t_faults();
      dom_req <= 1'b1;
      tick(50);
      chk({7'h0, drv_en}, 8'h00);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h26);
      dom_req <= 1'b0;
      tick(8);
      chk({7'h0, drv_en}, 8'h01);
      wr_reg(can_xcvr_pkg::REG_STATUS, 8'h02);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h24);
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h00);
      bus_dom <= 1'b1;
      tick(70);
      bus_dom <= 1'b0;
      // let the synchroniser drain so the clamp stops re-setting the flag
      tick(8);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h06);
      wr_reg(can_xcvr_pkg::REG_STATUS, 8'h02);
   endtask
   task automatic t_wake_norm();
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h01);
      wup();
      chk({6'h0, rx, int_n}, 8'h00);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h11);
      wr_reg(can_xcvr_pkg::REG_STATUS, 8'h01);
      tick(2);
      chk({7'h0, int_n}, 8'h01);
      wup();
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h10);
      chk({7'h0, rx}, 8'h00);
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h00);
      tick(2);
      chk({7'h0, rx}, 8'h01);
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h01);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h14);
   endtask
   task automatic t_wake_low();
      chip <= can_xcvr_pkg::CHIP_STOP;
      wr_reg(can_xcvr_pkg::REG_CTRL, 8'h05);
      wdog_seen <= 1'b0;
      wup();
      chk({6'h0, wdog_seen, int_n}, 8'h02);
      // host clears the wake and moves the chip itself
      wr_reg(can_xcvr_pkg::REG_STATUS, 8'h01);
      chip <= can_xcvr_pkg::CHIP_SLEEP;
      tick(3);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h14);
      rst_seen <= 1'b0;
      wup();
      chk({5'h0, rst_seen, int_n, rx}, 8'h06);
      rd_reg(can_xcvr_pkg::REG_STATUS, 8'h37);
      chk(st, 8'h11);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reset held five cycles, then the scenarios in order
   initial begin
      srst_in = 1'b1;
      {wr, rd, dom_req, bus_dom, rst_seen, wdog_seen} = 6'h00;
      addr = 4'h0;
      wdata = 8'h00;
      chip = can_xcvr_pkg::CHIP_NORMAL;
      miscompares = 0;
      n_compared = 0;
      cycles = 0;
      tick(5);
      srst_in <= 1'b0;
      tick(1);
      t_reset_off();
      t_modes();
      t_normal();
      t_faults();
      t_wake_norm();
      t_wake_low();
      final_report();
   end
endmodule
